// ---- core/hfc_pkg.sv ----
`default_nettype none
package hfc_pkg;
    // apb register map, byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_TEST  = 8'h04;
    localparam logic [7:0] A_TXW   = 8'h08;
    localparam logic [7:0] A_RXR   = 8'h0C;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_ISTAT = 8'h14;
    localparam logic [7:0] A_ICLR  = 8'h18;
    localparam logic [7:0] A_IEN   = 8'h1C;
    localparam logic [7:0] A_ADDR  = 8'h20;
    localparam logic [7:0] A_CRCX  = 8'h24;
    // hdlc_control_one fields
    localparam int B_RECEIVER_ENABLE_BIT = 9;
    localparam int B_TRANSMITTER_ENABLE_BIT = 8;
    localparam int B_EOP  = 7;
    localparam int B_FA   = 6;
    localparam int B_RXFL = 1;
    localparam int B_TXFL = 0;
    // hdlc_test_control fields
    localparam int B_SRST = 5;
    localparam int B_R2T  = 4;
    localparam int B_CRCT = 3;
    localparam int B_FIFO_PATH_SWAP_TEST = 2;
    localparam int B_ADT  = 1;
    localparam int B_T2R  = 0;
    // status fields
    localparam int S_RXEMPTY = 0;
    localparam int S_TXEMPTY = 1;
    localparam int S_TAGLO   = 2;
    localparam int S_TAGHI   = 3;
    localparam int S_VALID_ADDRESS_FLAG   = 4;
    localparam int S_CRCOK   = 5;
    localparam int S_CRCDONE = 6;
    localparam int S_ADDONE  = 7;
    localparam int S_RXFULL  = 8;
    localparam int S_TXFULL  = 9;
    // interrupt events
    localparam int IRQ_W     = 4;
    localparam int I_RXBYTE  = 0;
    localparam int I_RXEOP   = 1;
    localparam int I_TXEMPTY = 2;
    localparam int I_TDONE   = 3;
    // masks and reset values
    localparam logic [15:0] CTRL_MASK = 16'h03C3;
    localparam logic [15:0] TEST_MASK = 16'h003F;
    localparam logic [15:0] SRST_MASK = 16'h0020;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] TEST_RST  = 16'h0000;
    localparam logic [15:0] ADDR_RST  = 16'h0000;
    localparam logic [15:0] CRCX_RST  = 16'h0000;
    // serial framing constants
    localparam logic [7:0]  FLAG       = 8'h7E;
    localparam logic [7:0]  ABORT      = 8'hFF;
    localparam logic [15:0] CRC_INIT   = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_R = 16'h8408;
    localparam logic [15:0] CRC_EXPECT = 16'hF0B8;
    localparam logic [4:0]  TEST_BITS  = 5'h10;
    localparam logic [2:0]  LAST_BIT   = 3'h7;
    localparam logic [1:0]  HOLD_FULL  = 2'h3;
    localparam int          FIFO_AW    = 4;

    typedef struct packed {
        logic       abort;
        logic       eop;
        logic [7:0] data;
    } hfc_entry_s;

    typedef enum logic [2:0] {
        HFC_TX_FLAG = 3'b001,
        HFC_TX_DATA = 3'b010,
        HFC_TX_FCS  = 3'b100
    } hfc_tx_e;

    typedef struct packed {
        hfc_tx_e     st;
        logic [7:0]  sh;
        logic [2:0]  bcnt;
        logic [15:0] crc;
        logic        eop;
        logic        hi;
        logic [7:0]  fcs_hi;
    } hfc_tx_s;

    typedef struct packed {
        logic        inframe;
        logic [2:0]  bcnt;
        logic [1:0]  nb;
        logic [7:0]  sh;
        logic [23:0] hold;
    } hfc_rx_s;

    localparam hfc_tx_s TX_RST = '{st: HFC_TX_FLAG, sh: FLAG, default: '0};

    // one bit of the reflected frame check sequence
    function automatic logic [15:0] hfc_crc_bit(input logic [15:0] c, input logic b);
        hfc_crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY_R : 16'h0000);
    endfunction
endpackage
`default_nettype wire

// ---- core/hfc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module hfc_fifo import hfc_pkg::*; #(
    parameter int W  = 10,
    parameter int AW = FIFO_AW
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         clr,
    input  wire logic         flush,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] wdata,
    output var  logic [W-1:0] rdata_q,
    output logic              empty,
    output logic              full
);
    logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
    logic [W-1:0] mem [2**AW];
    logic         do_push, do_pop;

    assign empty = wr_q == rd_q;
    assign full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);

    // flush only moves the read pointer, stored words stay as they were
    always_comb begin
        do_push = push && !full;
        do_pop  = pop && !empty && !flush;
        wr_d    = wr_q + (AW+1)'(do_push);
        rd_d    = flush ? wr_q : rd_q + (AW+1)'(do_pop);
        if (clr) begin
            wr_d = '0;
            rd_d = '0;
        end
    end

    // head word is registered; bypass covers a write into the slot being read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q    <= '0;
            rd_q    <= '0;
            rdata_q <= '0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            rdata_q <= (do_push && wr_q[AW-1:0] == rd_d[AW-1:0]) ? wdata : mem[rd_d[AW-1:0]];
        end
    end

    // storage has no reset, contents survive flushes
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_q[AW-1:0]] <= wdata;
        end
    end

    a_flush_reads_empty: assert property (@(posedge mclk) disable iff (!rst_b)
        flush && !push |=> empty) else $error("flushed fifo not empty");
endmodule // hfc_fifo
`default_nettype wire

// ---- core/hfc_shift16.sv ----
`timescale 1ns/1ps
`default_nettype none
module hfc_shift16 import hfc_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic        bit_in,
    output var  logic [15:0] value_q,
    output logic             done,
    output logic             fin
);
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] value_d;

    assign done = cnt_q == TEST_BITS;
    assign fin  = en && !clr && cnt_q == TEST_BITS - 5'h01;

    // shift until sixteen bits are in, then freeze like a stopped clock
    always_comb begin
        value_d = value_q;
        cnt_d   = cnt_q;
        if (clr) begin
            value_d = '0;
            cnt_d   = '0;
        end else if (en && !done) begin
            value_d = {bit_in, value_q[15:1]};
            cnt_d   = cnt_q + 5'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            value_q <= '0;
            cnt_q   <= '0;
        end else begin
            value_q <= value_d;
            cnt_q   <= cnt_d;
        end
    end

    a_shift_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
        done && !clr |=> $stable(value_q) && done) else $error("shift moved after stop");
    a_shift_lands: assert property (@(posedge mclk) disable iff (!rst_b)
        fin |=> done ##1 done) else $error("shift did not stop at sixteen");
endmodule // hfc_shift16
`default_nettype wire

// ---- core/hfc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - receive flush shows receive fifo empty, receiver off until next flag, data kept
// - transmit flush shows transmit fifo empty, stored data untouched
// - transmit flush bit clears itself when a byte enters the transmit fifo
// - soft reset holds engine, control, test control and address registers reset
// - soft reset bit stays set until software writes zero or hardware reset
// - rx-to-tx loopback copies received bytes and end tag into transmit fifo too
// - looped bytes include bad packets and are sent like software-written bytes
// - crc test shifts sixteen serial bits into the compare register, then stops
// - a corruption mask can flip any compare bit in crc test
// - fifo test turns transmit writes into receive writes, receive reads into transmit reads
// - fifo test carries end and abort tags in, shows transmit tags in status
// - address test shifts sixteen bits in, then shows match against address register
// - tx-to-rx loopback feeds transmit serial output into receiver input
// - a fifo word is eight data bits plus end and abort tags
// - frame check sequence follows the byte tagged as packet end
// - receiver disable waits for frame end, enable takes effect at once
module hfc_core import hfc_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        receive_serial_clock,
    input  wire logic        rx_line_data,
    output logic             tx_line_data,
    output logic             irq
);
    logic [1:0]        rxc_s_q, rxd_s_q;
    logic              rxc_old_q, tick, rx_bit, srst;
    logic [15:0]       ctrl_q, ctrl_d, test_q, test_d, addr_q, addr_d, crcx_q, crcx_d, stat;
    logic [IRQ_W-1:0]  ist_q, ist_d, ien_q, ien_d, ev;
    logic [31:0]       rdat_d;
    logic              acc, wr_ctrl, wr_test, wr_txw, wr_iclr, wr_ien, wr_addr, wr_crcx, rd_rxr, mapped;
    hfc_rx_s           rx_q, rx_d;
    hfc_tx_s           tx_q, tx_d;
    hfc_entry_s        rx_ent, cpu_ent, rxf_wdata, txf_wdata, rxf_head, txf_head, head;
    logic              rx_push, rx_live, tx_pop, take, txe_old_q;
    logic              rxf_push, rxf_pop, rxf_empty, rxf_full, txf_push, txf_pop, txf_empty, txf_full;
    logic              fifo_path_swap_test, crc_done, crc_fin, adr_done, adr_fin, crc_ok, valid_address_flag;
    logic [15:0]       crc_val, adr_val;

    // pin synchronisers; only the second stage is looked at
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxc_s_q   <= '0;
            rxd_s_q   <= '0;
            rxc_old_q <= 1'b0;
        end else begin
            rxc_s_q   <= {rxc_s_q[0], receive_serial_clock};
            rxd_s_q   <= {rxd_s_q[0], rx_line_data};
            rxc_old_q <= rxc_s_q[1];
        end
    end
    assign tick = rxc_s_q[1] && !rxc_old_q;   // rising serial clock edge
    assign srst = test_q[B_SRST];
    assign fifo_path_swap_test = test_q[B_FIFO_PATH_SWAP_TEST];

    assign rx_bit       = test_q[B_T2R] ? tx_q.sh[0] : rxd_s_q[1];
    assign tx_line_data = tx_q.sh[0];

    // apb decode; zero wait states so pready is tied high
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign mapped  = paddr inside {A_CTRL, A_TEST, A_TXW, A_RXR, A_STAT, A_ISTAT, A_ICLR, A_IEN, A_ADDR, A_CRCX};
    assign pslverr = acc && !mapped;
    assign wr_ctrl = acc && pwrite && paddr == A_CTRL;
    assign wr_test = acc && pwrite && paddr == A_TEST;
    assign wr_txw  = acc && pwrite && paddr == A_TXW;
    assign wr_iclr = acc && pwrite && paddr == A_ICLR;
    assign wr_ien  = acc && pwrite && paddr == A_IEN;
    assign wr_addr = acc && pwrite && paddr == A_ADDR;
    assign wr_crcx = acc && pwrite && paddr == A_CRCX;
    assign rd_rxr  = acc && !pwrite && paddr == A_RXR;

    assign cpu_ent = '{abort: ctrl_q[B_FA], eop: ctrl_q[B_EOP], data: pwdata[7:0]};

    // fifo steering; the receive engine wins a slot over a cpu write
    always_comb begin
        rxf_push  = rx_push || (wr_txw && fifo_path_swap_test);
        rxf_pop   = rd_rxr && !fifo_path_swap_test;
        rxf_wdata = rx_push ? rx_ent : cpu_ent;
        txf_push  = (rx_push && test_q[B_R2T]) || (wr_txw && !fifo_path_swap_test);
        txf_wdata = (rx_push && test_q[B_R2T]) ? rx_ent : cpu_ent;
        txf_pop   = tx_pop || (rd_rxr && fifo_path_swap_test);
        head      = fifo_path_swap_test ? txf_head : rxf_head;
    end

    // control registers; self-clearing bits lose to a software write
    always_comb begin
        ctrl_d = ctrl_q;
        test_d = test_q;
        addr_d = addr_q;
        crcx_d = crcx_q;
        ien_d  = wr_ien ? pwdata[IRQ_W-1:0] : ien_q;
        if (wr_txw) begin
            ctrl_d[B_EOP] = 1'b0;
            ctrl_d[B_FA]  = 1'b0;
        end
        if (txf_push) begin
            ctrl_d[B_TXFL] = 1'b0;
        end
        if (wr_ctrl) ctrl_d = pwdata[15:0] & CTRL_MASK;
        if (wr_test) test_d = pwdata[15:0] & TEST_MASK;
        if (wr_addr) addr_d = pwdata[15:0];
        if (wr_crcx) crcx_d = pwdata[15:0];
        if (srst) begin
            ctrl_d = CTRL_RST;
            addr_d = ADDR_RST;
            crcx_d = CRCX_RST;
            test_d = test_d & SRST_MASK;
        end
    end

    // receive engine: flag hunt, byte assembly, three-byte hold drops the fcs
    always_comb begin
        rx_d    = rx_q;
        rx_push = 1'b0;
        rx_ent  = '{abort: 1'b0, eop: 1'b0, data: rx_q.hold[23:16]};
        rx_live = (ctrl_q[B_RECEIVER_ENABLE_BIT] || rx_q.inframe) && !test_q[B_CRCT] && !test_q[B_ADT];
        if (ctrl_q[B_RXFL]) begin
            rx_d.inframe = 1'b0;
            rx_d.nb      = '0;
        end else if (tick && rx_live) begin
            rx_d.sh = {rx_bit, rx_q.sh[7:1]};
            if (rx_d.sh == FLAG) begin
                // no fcs check, bad packets loop too
                rx_push      = rx_q.inframe && rx_q.nb == HOLD_FULL;
                rx_ent.eop   = 1'b1;
                rx_d.inframe = ctrl_q[B_RECEIVER_ENABLE_BIT];
                rx_d.bcnt    = '0;
                rx_d.nb      = '0;
            end else if (rx_q.inframe) begin
                rx_d.bcnt = rx_q.bcnt + 3'h1;
                if (rx_q.bcnt == LAST_BIT) begin
                    rx_push   = rx_q.nb == HOLD_FULL;
                    rx_d.hold = {rx_q.hold[15:0], rx_d.sh};
                    rx_d.nb   = (rx_q.nb == HOLD_FULL) ? HOLD_FULL : rx_q.nb + 2'h1;
                end
            end
        end
    end

    // transmit engine on the serial clock; no zero insertion is done
    always_comb begin
        tx_d   = tx_q;
        tx_pop = 1'b0;
        take   = 1'b0;
        if (tick) begin
            tx_d.sh   = {1'b0, tx_q.sh[7:1]};
            tx_d.bcnt = tx_q.bcnt + 3'h1;
            if (tx_q.st == HFC_TX_DATA) begin
                tx_d.crc = hfc_crc_bit(tx_q.crc, tx_q.sh[0]);
            end
            if (tx_q.bcnt == LAST_BIT) begin
                case (tx_q.st)
                    HFC_TX_DATA: begin
                        if (tx_q.eop) begin
                            tx_d.st     = HFC_TX_FCS;
                            tx_d.sh     = ~tx_d.crc[7:0];
                            tx_d.fcs_hi = ~tx_d.crc[15:8];
                            tx_d.hi     = 1'b0;
                        end else if (!txf_empty && !fifo_path_swap_test) begin
                            take = 1'b1;
                        end else begin
                            tx_d.st = HFC_TX_FLAG;   // underrun aborts the frame
                            tx_d.sh = ABORT;
                        end
                    end
                    HFC_TX_FCS: begin
                        tx_d.hi = 1'b1;
                        tx_d.sh = tx_q.fcs_hi;
                        if (tx_q.hi) begin
                            tx_d.st = HFC_TX_FLAG;
                            tx_d.sh = FLAG;
                        end
                    end
                    default: begin
                        tx_d.sh  = FLAG;
                        tx_d.crc = CRC_INIT;
                        take     = ctrl_q[B_TRANSMITTER_ENABLE_BIT] && !txf_empty && !fifo_path_swap_test;
                    end
                endcase
            end
        end
        if (take) begin
            tx_pop   = 1'b1;
            tx_d.eop = txf_head.eop;
            tx_d.st  = txf_head.abort ? HFC_TX_FLAG : HFC_TX_DATA;
            tx_d.sh  = txf_head.abort ? ABORT : txf_head.data;
        end
    end

    // interrupt status: a new event beats a clear in the same cycle
    always_comb begin
        ev            = '0;
        ev[I_RXBYTE]  = rxf_push;
        ev[I_RXEOP]   = rxf_push && rxf_wdata.eop;
        ev[I_TXEMPTY] = txf_empty && !txe_old_q;
        ev[I_TDONE]   = crc_fin || adr_fin;
        ist_d         = (ist_q & ~(wr_iclr ? pwdata[IRQ_W-1:0] : '0)) | ev;
    end
    assign irq = |(ist_q & ien_q);

    assign crc_ok = (crc_val ^ crcx_q) == CRC_EXPECT;
    assign valid_address_flag  = adr_done && adr_val == addr_q;

    // status word; tag bits follow whichever fifo the read port faces
    always_comb begin
        stat            = '0;
        stat[S_RXEMPTY] = rxf_empty;
        stat[S_TXEMPTY] = txf_empty;
        stat[S_TAGLO]   = head.eop;
        stat[S_TAGHI]   = head.abort;
        stat[S_VALID_ADDRESS_FLAG]   = valid_address_flag;
        stat[S_CRCOK]   = crc_done && crc_ok;
        stat[S_CRCDONE] = crc_done;
        stat[S_ADDONE]  = adr_done;
        stat[S_RXFULL]  = rxf_full;
        stat[S_TXFULL]  = txf_full;
    end

    // read data is captured in the setup phase so pready can stay high
    always_comb begin
        rdat_d = prdata;
        if (psel && !penable) begin
            case (paddr)
                A_CTRL:  rdat_d = {16'h0000, ctrl_q};
                A_TEST:  rdat_d = {16'h0000, test_q};
                A_RXR:   rdat_d = {22'h0, head};
                A_STAT:  rdat_d = {16'h0000, stat};
                A_ISTAT: rdat_d = {28'h0000000, ist_q};
                A_IEN:   rdat_d = {28'h0000000, ien_q};
                A_ADDR:  rdat_d = {16'h0000, addr_q};
                A_CRCX:  rdat_d = {16'h0000, crcx_q};
                default: rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q    <= CTRL_RST;
            test_q    <= TEST_RST;
            addr_q    <= ADDR_RST;
            crcx_q    <= CRCX_RST;
            ien_q     <= '0;
            ist_q     <= '0;
            prdata    <= '0;
            rx_q      <= '0;
            tx_q      <= TX_RST;
            txe_old_q <= 1'b1;
        end else begin
            ctrl_q    <= ctrl_d;
            test_q    <= test_d;
            addr_q    <= addr_d;
            crcx_q    <= crcx_d;
            ien_q     <= ien_d;
            ist_q     <= ist_d;
            prdata    <= rdat_d;
            rx_q      <= srst ? '0 : rx_d;
            tx_q      <= srst ? TX_RST : tx_d;
            txe_old_q <= txf_empty;
        end
    end

    hfc_fifo #(.W($bits(hfc_entry_s)), .AW(FIFO_AW)) u_rxf (
        .mclk(mclk), .rst_b(rst_b), .clr(srst), .flush(ctrl_q[B_RXFL]), .push(rxf_push),
        .pop(rxf_pop), .wdata(rxf_wdata), .rdata_q(rxf_head), .empty(rxf_empty), .full(rxf_full));
    hfc_fifo #(.W($bits(hfc_entry_s)), .AW(FIFO_AW)) u_txf (
        .mclk(mclk), .rst_b(rst_b), .clr(srst), .flush(ctrl_q[B_TXFL]), .push(txf_push),
        .pop(txf_pop), .wdata(txf_wdata), .rdata_q(txf_head), .empty(txf_empty), .full(txf_full));
    hfc_shift16 u_crc (
        .mclk(mclk), .rst_b(rst_b), .clr(srst || !test_q[B_CRCT]), .en(tick && test_q[B_CRCT]),
        .bit_in(rx_bit), .value_q(crc_val), .done(crc_done), .fin(crc_fin));
    hfc_shift16 u_adr (
        .mclk(mclk), .rst_b(rst_b), .clr(srst || !test_q[B_ADT]), .en(tick && test_q[B_ADT]),
        .bit_in(rx_bit), .value_q(adr_val), .done(adr_done), .fin(adr_fin));

    a_rxflush_empty: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl_q[B_RXFL] |=> rxf_empty || $past(rxf_push)) else $error("rx fifo not empty under flush");
    a_txflush_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        txf_push && !wr_ctrl && !srst |=> !ctrl_q[B_TXFL]) else $error("tx flush bit not cleared");
    a_srst_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        srst |=> ctrl_q == CTRL_RST && addr_q == ADDR_RST && (test_q & ~SRST_MASK) == '0)
        else $error("registers not held by soft reset");
    a_srst_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
        srst && !wr_test |=> srst) else $error("soft reset bit dropped");
    a_loop_copy: assert property (@(posedge mclk) disable iff (!rst_b)
        rx_push && test_q[B_R2T] |-> txf_push && txf_wdata == rx_ent) else $error("loop byte not copied");
    a_fifo_path_swap_test_redirect: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_txw && fifo_path_swap_test && !rx_push |-> rxf_push && !(txf_push && !test_q[B_R2T]))
        else $error("fifo test write not redirected");
    a_eop_fcs: assert property (@(posedge mclk) disable iff (!rst_b)
        tick && !srst && tx_q.st == HFC_TX_DATA && tx_q.bcnt == LAST_BIT && tx_q.eop
        |=> tx_q.st == HFC_TX_FCS && !tx_q.hi) else $error("no fcs after end byte");
    a_t2r_source: assert property (@(posedge mclk) disable iff (!rst_b)
        test_q[B_T2R] |-> rx_bit == tx_line_data) else $error("loopback not routed");
endmodule // hfc_core
`default_nettype wire

// ---- test/hfc_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hfc_line_model (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic [15:0] pattern,
    output var  logic        sclk,
    output var  logic        sdata,
    output var  logic        busy
);
    logic [7:0] cnt_q = 8'h00;
    initial {sclk, sdata, busy} = 3'h0;
    // bit clock at mclk/8, still between bursts; data inverts once at burst end so no stale level
    always @(posedge mclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt_q <= 8'h00;
        end else if (busy) begin
            cnt_q <= cnt_q + 8'h01;
            sclk <= cnt_q[2];
            if (cnt_q[2:0] == 3'h0) sdata <= pattern[cnt_q[6:3]];
            if (cnt_q == 8'h80) begin
                busy <= 1'b0;
                sclk <= 1'b0;
                sdata <= ~sdata;
            end
        end
    end
endmodule // hfc_line_model
`default_nettype wire

// ---- test/hdlc_fifo_reset_and_test_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_reset_and_test_control_tb;
    import hfc_pkg::*;
    logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 32'h34A6525B, exp_q[$], msk_q[$];
    logic [15:0] pattern = 0;
    logic pready, pslverr, sclk, sdata, txd, irq, busy;
    int n_fail = 0, compares = 0;
    localparam logic [7:0] A_BAD = 8'h40;   // an address outside the register map
    always #5 mclk = ~mclk;
    hfc_core u_hfc_core (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_serial_clock(sclk), .rx_line_data(sdata), .tx_line_data(txd), .irq(irq));
    hfc_line_model u_hfc_line_model (.mclk(mclk), .go(go), .pattern(pattern), .sclk(sclk),
        .sdata(sdata), .busy(busy));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m);
        exp_q.push_back(want);
        msk_q.push_back(m);
        apb(0, a, 0);
    endtask
    // shift one 16-bit burst in from the line model
    task automatic send(input logic [15:0] p);
        int i;
        i = 0;
        pattern <= p;
        go <= 1;
        @(posedge mclk);
        go <= 0;
        @(posedge mclk);
        while (busy && i < 300) begin
            @(posedge mclk);
            i++;
        end
        if (busy) n_fail++;   // burst never ended
        repeat (6) @(posedge mclk);
    endtask
    // read results are compared against the oldest note
    always @(posedge mclk) if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        check(prdata & msk_q.pop_front(), exp_q.pop_front());
    // only the unmapped address may raise a bus error
    always @(posedge mclk) if (psel && penable && pready) check(pslverr, paddr == A_BAD);
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1;
        @(posedge mclk);
        rd(A_CTRL, CTRL_RST, '1);
        rd(A_TEST, TEST_RST, '1);
        rd(A_BAD, 0, '1);
        seed = xs(seed);
        apb(1, A_TXW, {24'h0, seed[7:0]});
        rd(A_STAT, 0, 32'h2);
        apb(1, A_CTRL, 32'h1);
        rd(A_STAT, 32'h2, 32'h2);
        apb(1, A_TXW, 32'h3C);
        rd(A_CTRL, 0, 32'h1);
        $display("flush test done");
        apb(1, A_CTRL, 32'h300);
        apb(1, A_TEST, 32'h20);
        rd(A_CTRL, 0, '1);
        apb(1, A_TEST, 32'h24);
        rd(A_TEST, 32'h20, '1);
        apb(1, A_TEST, 0);
        rd(A_TEST, 0, '1);
        $display("soft reset test done");
        apb(1, A_IEN, 32'h1);
        apb(1, A_TEST, 32'h1 << B_FIFO_PATH_SWAP_TEST);
        apb(1, A_CTRL, 32'h1 << B_EOP);
        apb(1, A_TXW, 32'h5A);
        apb(1, A_TXW, {24'h0, seed[15:8]});
        rd(A_STAT, 32'h2, 32'h3);
        check(irq, 1);
        apb(1, A_IEN, 0);
        check(irq, 0);
        apb(1, A_IEN, 32'h1);
        apb(1, A_ICLR, 32'h1);
        check(irq, 0);
        apb(1, A_TEST, 0);
        rd(A_RXR, 32'h15A, 32'h3FF);
        // one byte is left behind; the flush must hide it
        apb(1, A_CTRL, 32'h1 << B_RXFL);
        rd(A_STAT, 32'h1, 32'h1);
        $display("fifo test done");
        apb(1, A_TEST, 32'h1 << B_CRCT);
        send(CRC_EXPECT);
        rd(A_STAT, 32'h60, 32'h60);
        seed = xs(seed);
        apb(1, A_CRCX, 32'h1 << seed[3:0]);
        rd(A_STAT, 32'h40, 32'h60);
        apb(1, A_TEST, 0);
        apb(1, A_ADDR, {16'h0, seed[31:16]});
        apb(1, A_TEST, 32'h1 << B_ADT);
        send(seed[31:16]);
        rd(A_STAT, 32'h90, 32'h90);
        $display("shift test done");
        // frame of three bytes, the last two taken as fcs, is copied to both fifos
        apb(1, A_CTRL, 32'h1 << B_RECEIVER_ENABLE_BIT);
        apb(1, A_TEST, 32'h1 << B_R2T);
        seed = xs(seed);
        send({4'h0, seed[3:0], FLAG});
        send(16'h0000);
        send({FLAG, FLAG});
        rd(A_RXR, {23'h0, 1'b1, 4'h0, seed[3:0]}, 32'h3FF);
        apb(1, A_TEST, 32'h1 << B_FIFO_PATH_SWAP_TEST);
        rd(A_RXR, {23'h0, 1'b1, 4'h0, seed[3:0]}, 32'h3FF);
        $display("loopback test done");
        // idle flags looped back fill the compare register instead of the line pattern
        apb(1, A_TEST, 0);
        apb(1, A_CTRL, (32'h1 << B_RECEIVER_ENABLE_BIT) | (32'h1 << B_TRANSMITTER_ENABLE_BIT));
        apb(1, A_CRCX, {16'h0, FLAG, FLAG} ^ {16'h0, CRC_EXPECT});
        apb(1, A_TEST, (32'h1 << B_T2R) | (32'h1 << B_CRCT));
        send(CRC_EXPECT);
        rd(A_STAT, 32'h60, 32'h60);
        check(txd, FLAG[0]);
        $display("tx to rx loopback test done");
        print_verdict;
    end
endmodule // hdlc_fifo_reset_and_test_control_tb
`default_nettype wire
